//--- design/wdog_pkg.sv
package wdog_pkg;

  // ==========================================================================
  // Register map
  localparam logic [31:0] SERVICE_ADDR = 32'h0000_0017;
  localparam logic [31:0] SERVICE_IDX = 32'h0000_0017;
  localparam logic [31:0] CTRL_IDX = 32'h0000_0016;
  localparam logic [31:0] MODE_IDX = 32'h0000_0018;
  localparam logic [31:0] STATUS_IDX = 32'h0000_0019;
  localparam logic [11:0] SERVICE_OFS = 12'h05C;
  localparam logic [11:0] CTRL_OFS = 12'h058;
  localparam logic [11:0] MODE_OFS = 12'h060;
  localparam logic [11:0] STATUS_OFS = 12'h064;

  // ==========================================================================
  // Control register fields
  localparam int RATE_LSB = 0;
  localparam int SUPPRESS_BIT = 3;
  localparam int FORCE_BIT = 4;
  localparam int WAIT_HALT_BIT = 5;
  localparam int DEBUG_HALT_BIT = 6;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ==========================================================================
  // Service keys and timing
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  localparam int PRESCALE_LOG2 = 13;
  localparam logic [2:0] RATE_OFF = 3'h0;

  typedef struct packed {
    logic debug_mode_halt;
    logic wait_mode_halt;
    logic force_wdog_test_reset;
    logic reset_suppress;
    logic [2:0] wdog_rate_sel;
  } wdog_ctrl_t;

  typedef enum logic [1:0] {
    KEY_IDLE = 2'b00,
    KEY_ARMED = 2'b01
  } key_state_t;

endpackage : wdog_pkg

//--- design/wdog_prescaler.sv
`timescale 1ns/1ps
// ============================================================================
// Free-running prescaler: one-cycle tick every 2**LOG2 enabled clocks.
module wdog_prescaler #(
  parameter int LOG2 = 13
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  output logic tick
);
  logic [LOG2-1:0] count;
  wire logic wrap = run && (count == {LOG2{1'b1}});

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= '0;
      tick <= 1'b0;
    end else begin
      if (run) begin
        count <= count + 1'b1;
      end
      tick <= wrap;
    end
  end
endmodule : wdog_prescaler

//--- design/wdog_timeout.sv
`timescale 1ns/1ps
// ============================================================================
// Timeout counter clocked by prescaler ticks; expire is a one-cycle pulse.
module wdog_timeout
  import wdog_pkg::*;
#(
  parameter int WIDTH = 10
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic tick,
  input wire logic restart,
  input wire logic [2:0] rate,
  output logic expire
);
  logic [WIDTH-1:0] count;
  logic [WIDTH-1:0] limit;

  // Total divisor 2^13 times 1,4,16,64,256,512,1024.
  always_comb begin
    case (rate)
      3'h1: limit = WIDTH'(0);
      3'h2: limit = WIDTH'(3);
      3'h3: limit = WIDTH'(15);
      3'h4: limit = WIDTH'(63);
      3'h5: limit = WIDTH'(255);
      3'h6: limit = WIDTH'(511);
      3'h7: limit = WIDTH'(1023);
      default: limit = '0;
    endcase
  end

  wire logic hit = tick && (rate != RATE_OFF) && (count >= limit);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count <= '0;
      expire <= 1'b0;
    end else begin
      expire <= hit && !restart;
      if (restart || rate == RATE_OFF || hit) begin
        count <= '0;
      end else if (tick) begin
        count <= count + 1'b1;
      end
    end
  end
endmodule : wdog_timeout

//--- design/wdog_top.sv
`timescale 1ns/1ps
// How it works
// [R01] With the force-test bit set and the watchdog on, a timeout resets via the test path.
// [R02] The force-test bit does nothing while the reset-suppress bit is set.
// [R03] The reset-suppress bit blocks watchdog and clock-monitor resets.
// [R04] Force-test and reset-suppress bits are writable only in special mode.
// [R05] The rate field takes one write in normal mode and any write in special mode.
// [R06] A fixed prescaler divides the module clock by 2^13 before the rate divider.
// [R07] Rate 0 is off; 1..7 give total divisors 2^13,15,17,19,21,22,23.
// [R08] Software writes 0x55 then 0xAA to the service register to restart the period.
// [R09] Other bus traffic between the two key writes does not break the sequence.
// [R10] Any other value written to the service register resets at once.
// [R11] A timeout without a completed service causes a system reset.
// [R12] With the wait-halt bit set the watchdog stops in wait mode.
// [R13] With the debug-halt bit set the watchdog stops in background debug mode.
// [R14] 0xAA restarts only if the previous service write was 0x55; prescaler runs free.
// [R15] The service register reads as zero and stores nothing.
module wdog_top
  import wdog_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Chip state
  input wire logic SPECIAL_MODE,
  input wire logic WAIT_MODE,
  input wire logic DEBUG_MODE,
  input wire logic CLOCK_MONITOR_FAIL,
  // Reset requests
  output logic SYSTEM_RESET_REQ,
  output logic TEST_RESET_REQ
);

  // ==========================================================================
  // Bus decode
  wdog_ctrl_t ctrl;
  logic rate_written;
  logic key_armed;
  logic timeout_seen;
  logic bad_key_seen;

  wire logic access = PSEL && PENABLE;
  wire logic wr = access && PWRITE;
  wire logic hit_ctrl = (PADDR == CTRL_OFS);
  wire logic hit_service = (PADDR == SERVICE_OFS);
  wire logic hit_mode = (PADDR == MODE_OFS);
  wire logic hit_status = (PADDR == STATUS_OFS);
  wire logic mapped = hit_ctrl || hit_service || hit_mode || hit_status;
  wire logic [7:0] wbyte = PWDATA[7:0];
  wire logic ctrl_wr = wr && hit_ctrl;
  wire logic service_wr = wr && hit_service;

  // The service register reads back zero; its value is never kept.
  wire logic [31:0] read_mux =
    hit_ctrl ? {25'h0, ctrl} : // see [R15]
    hit_mode ? {29'h0, DEBUG_MODE, WAIT_MODE, SPECIAL_MODE} :
    hit_status ? {29'h0, bad_key_seen, timeout_seen, key_armed} :
    32'h0000_0000;

  // ==========================================================================
  // Control register with mode-dependent write permission
  wire logic rate_ok = SPECIAL_MODE || !rate_written; // see [R05]
  wdog_ctrl_t next_ctrl;
  always_comb begin
    next_ctrl = ctrl;
    if (ctrl_wr) begin
      next_ctrl.wait_mode_halt = wbyte[WAIT_HALT_BIT];
      next_ctrl.debug_mode_halt = wbyte[DEBUG_HALT_BIT];
      if (SPECIAL_MODE) begin
        next_ctrl.force_wdog_test_reset = wbyte[FORCE_BIT]; // see [R04]
        next_ctrl.reset_suppress = wbyte[SUPPRESS_BIT];
      end
      if (rate_ok) begin
        next_ctrl.wdog_rate_sel = wbyte[RATE_LSB +: 3];
      end
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ctrl <= wdog_ctrl_t'(CTRL_RESET[$bits(wdog_ctrl_t)-1:0]);
      rate_written <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      if (ctrl_wr) begin
        rate_written <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Service key sequence
  // Only service-register writes move the state, so other traffic is harmless.
  wire logic is_first = (wbyte == KEY_FIRST);
  wire logic is_second = (wbyte == KEY_SECOND);
  wire logic bad_key = service_wr && !is_first && !is_second; // see [R10]
  wire logic restart = service_wr && is_second && key_armed; // see [R08] [R14]

  key_state_t key_state;
  key_state_t next_key_state;
  always_comb begin
    next_key_state = key_state;
    if (service_wr) begin // see [R09]
      case (key_state)
        KEY_IDLE: next_key_state = is_first ? KEY_ARMED : KEY_IDLE;
        KEY_ARMED: next_key_state = is_first ? KEY_ARMED : KEY_IDLE;
        default: next_key_state = KEY_IDLE;
      endcase
    end
  end
  assign key_armed = (key_state == KEY_ARMED);

  // ==========================================================================
  // Counting chain
  wire logic halted = (WAIT_MODE && ctrl.wait_mode_halt) || // see [R12]
                      (DEBUG_MODE && ctrl.debug_mode_halt); // see [R13]
  logic tick;
  logic expire;

  // The prescaler is never restarted, so a serviced period may be short.
  wdog_prescaler #(
    .LOG2(PRESCALE_LOG2) // see [R06]
  ) u_prescaler (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .run(!halted),
    .tick(tick)
  );

  wdog_timeout #(
    .WIDTH(10)
  ) u_timeout (
    .clk(SYS_CLK),
    .rst_n(RST_N),
    .tick(tick),
    .restart(restart),
    .rate(ctrl.wdog_rate_sel), // see [R07]
    .expire(expire)
  );

  // ==========================================================================
  // Reset generation
  wire logic wdog_event = expire || bad_key; // see [R11]
  wire logic suppress = ctrl.reset_suppress; // see [R03]
  wire logic next_sys = !suppress && (wdog_event || CLOCK_MONITOR_FAIL);
  wire logic next_test = !suppress && ctrl.force_wdog_test_reset && expire; // see [R01] [R02]

  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      key_state <= KEY_IDLE;
      PRDATA <= 32'h0000_0000;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      SYSTEM_RESET_REQ <= 1'b0;
      TEST_RESET_REQ <= 1'b0;
      timeout_seen <= 1'b0;
      bad_key_seen <= 1'b0;
    end else begin
      key_state <= next_key_state;
      PREADY <= PSEL && !PENABLE;
      PSLVERR <= PSEL && !PENABLE && !mapped;
      PRDATA <= (PSEL && !PENABLE && !PWRITE) ? read_mux : 32'h0000_0000;
      SYSTEM_RESET_REQ <= next_sys;
      TEST_RESET_REQ <= next_test;
      timeout_seen <= timeout_seen || expire;
      bad_key_seen <= bad_key_seen || bad_key;
    end
  end

endmodule : wdog_top

//--- verif/wdog_props.sv
`timescale 1ns/1ps
// ============================================================
// Port checker for the watchdog block.
module wdog_props
  import wdog_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  // Chip state
  input wire logic SPECIAL_MODE,
  input wire logic WAIT_MODE,
  input wire logic DEBUG_MODE,
  input wire logic CLOCK_MONITOR_FAIL,
  // Reset requests
  input wire logic SYSTEM_RESET_REQ,
  input wire logic TEST_RESET_REQ
);
  logic sup;
  wire logic acc = PSEL && PENABLE && PREADY && PWRITE;
  wire logic svc = acc && PADDR == SERVICE_OFS;
  wire logic good_key = PWDATA[7:0] == KEY_FIRST || PWDATA[7:0] == KEY_SECOND;
  wire logic mapped = PADDR inside {CTRL_OFS, SERVICE_OFS, MODE_OFS, STATUS_OFS};
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  // Shadow of the suppress bit, which only special mode may change.
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N)
      sup <= 1'b0;
    else if (acc && PADDR == CTRL_OFS && SPECIAL_MODE)
      sup <= PWDATA[SUPPRESS_BIT];
  end
  a_ready_pulse: assert property (PREADY |=> !PREADY) else $error("ready held");
  a_setup_answer: assert property (PSEL && !PENABLE |=> PREADY) else $error("no answer");
  a_unmapped_err: assert property (PREADY |-> PSLVERR == !mapped) else $error("slverr wrong");
  a_service_zero: assert property (
    PREADY && !PWRITE && PADDR == SERVICE_OFS |-> PRDATA == '0)
    else $error("service read not zero");
  a_ctrl_lock: assert property (
    PREADY && !PWRITE && PADDR == CTRL_OFS |-> PRDATA[SUPPRESS_BIT] == sup)
    else $error("suppress bit wrong");
  a_bad_key: assert property (svc && !good_key && !sup |-> ##[1:2] SYSTEM_RESET_REQ)
    else $error("bad key no reset");
  a_test_path: assert property (TEST_RESET_REQ |-> SYSTEM_RESET_REQ)
    else $error("test reset alone");
  a_suppress_blocks: assert property (
    sup && $past(sup, 2) |-> !SYSTEM_RESET_REQ && !TEST_RESET_REQ)
    else $error("reset while suppressed");
  a_clkmon_reset: assert property (
    $rose(CLOCK_MONITOR_FAIL) && !sup |-> ##[1:2] SYSTEM_RESET_REQ)
    else $error("clock monitor no reset");
endmodule : wdog_props

bind wdog_top wdog_props wdog_props_inst (.SYS_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR,
  .PWDATA, .PRDATA, .PREADY, .PSLVERR, .SPECIAL_MODE, .WAIT_MODE, .DEBUG_MODE,
  .CLOCK_MONITOR_FAIL, .SYSTEM_RESET_REQ, .TEST_RESET_REQ);

//--- verif/watchdog_timer_with_service_key_tb_top.sv
`timescale 1ns/1ps
// ============================================================
// Self-checking bench for the watchdog block.
module watchdog_timer_with_service_key_tb_top
  import wdog_pkg::*;
;
  logic SYS_CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic SPECIAL_MODE = 0, WAIT_MODE = 0, DEBUG_MODE = 0, CLOCK_MONITOR_FAIL = 0;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, PRDATA, rd;
  logic PREADY, PSLVERR, SYSTEM_RESET_REQ, TEST_RESET_REQ, se;
  int err_count = 0, tests_run = 0, sys_n = 0, tst_n = 0, v, s;
  wdog_top wdog_top_inst (.SYS_CLK, .RST_N, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .SPECIAL_MODE, .WAIT_MODE, .DEBUG_MODE, .CLOCK_MONITOR_FAIL,
    .SYSTEM_RESET_REQ, .TEST_RESET_REQ);
  initial forever #25 SYS_CLK = ~SYS_CLK;
  always @(negedge SYS_CLK) begin
    sys_n += int'(SYSTEM_RESET_REQ === 1'b1);
    tst_n += int'(TEST_RESET_REQ === 1'b1);
  end
  task chk(input bit ok, input string m);
    tests_run++;
    if (!ok) begin
      err_count++;
      $display("ERROR %0t %s", $time, m);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask : cyc
  // Ready and read data are taken at the rising edge, as they stood just before it.
  // Only the watchdog ends a wait that never sees ready.
  task apb(input bit w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge SYS_CLK);
      n++;
    end while (PREADY !== 1'b1);
    chk(n == 1, "ready late");
    rd = PRDATA;
    se = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb
  task expect_rst(input int n, input bit fire, input string m);
    s = sys_n;
    cyc(n);
    chk((sys_n != s) == fire, m);
  endtask : expect_rst
  task stop_test;
    if (err_count == 0 && tests_run > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  initial begin
    cyc(98000);
    err_count++;
    stop_test;
  end
  initial begin
    v = $urandom(19200);
    cyc(8);
    RST_N <= 1'b1;
    expect_rst(3000, 0, "off");
    apb(0, SERVICE_OFS, 0);
    chk(rd === 32'h0 && se === 1'b0, "service read");
    apb(0, 12'h0FC, 0);
    chk(se === 1'b1, "unmapped");
    apb(1, CTRL_OFS, 32'h1A);
    apb(1, CTRL_OFS, 32'h03);
    apb(0, CTRL_OFS, 0);
    chk(rd[4:0] === 5'h02, "normal mode lock");
    // Three serviced spans outlast one unserviced timeout, so a lost restart shows.
    repeat (3) begin
      apb(1, SERVICE_OFS, KEY_FIRST);
      apb(0, STATUS_OFS, 0);
      chk(rd[0] === 1'b1, "key not armed");
      apb(1, SERVICE_OFS, KEY_SECOND);
      expect_rst(10500 + $urandom_range(0, 1500), 0, "serviced");
    end
    v = $urandom_range(0, 255);
    if (v == 8'h55 || v == 8'hAA)
      v = 0;
    apb(1, SERVICE_OFS, v);
    expect_rst(4, 1, "bad key");
    expect_rst(22500, 1, "timeout");
    SPECIAL_MODE <= 1'b1;
    RST_N <= 1'b0;
    cyc(8);
    RST_N <= 1'b1;
    for (int c = 7; c >= 0; c--) begin
      apb(1, CTRL_OFS, c);
      apb(0, CTRL_OFS, 0);
      chk(rd[2:0] === c[2:0], "rate rewrite");
    end
    apb(1, CTRL_OFS, 32'h11);
    v = tst_n;
    expect_rst(8300, 1, "forced timeout");
    chk(tst_n > v, "test reset");
    apb(1, CTRL_OFS, 32'h19);
    CLOCK_MONITOR_FAIL <= 1'b1;
    apb(1, SERVICE_OFS, 32'h12);
    expect_rst(8500, 0, "suppressed");
    CLOCK_MONITOR_FAIL <= 1'b0;
    apb(1, CTRL_OFS, 0);
    CLOCK_MONITOR_FAIL <= 1'b1;
    expect_rst(4, 1, "clock monitor");
    CLOCK_MONITOR_FAIL <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      apb(1, CTRL_OFS, k ? 32'h41 : 32'h21);
      WAIT_MODE <= k == 0;
      DEBUG_MODE <= k == 1;
      expect_rst(8500, 0, "halted");
    end
    stop_test;
  end
endmodule : watchdog_timer_with_service_key_tb_top
